// File: common/smrrb_pkg.sv
// Notes on behaviour
// - precharge all, wait precharge time, then MRS; the code checks this only for an MRS to MR3 with A2=1
// - MR3 A2=1, A[1:0]=00 enables pattern reads
// - wait mode register delays before pattern read
// - no write while pattern mode is on
// - 8-beat pattern read: A[2:0] zero, order 0..7
// - 8-beat pattern read drives chop bit high
// - chopped pattern read: A2 picks nibble
// - activate opens row in bank until precharge
// - precharge before activating another row
// - precharge closes rows; reopen after precharge time
// - reads during auto precharge must not collide
// - idle bank needs activate before read/write
// - repeated precharge restarts the precharge period
// - chop bit low: 4 beats; high: 8
// - chop bit never used as column address
// - pattern is 0,1,0,1,... from beat 0
// - pattern bit replicated on every data line
// - pattern mode allows only reads until cleared
package smrrb_pkg;
  // ----------------------------------------
  // link widths
  // ----------------------------------------
  localparam int DQ_W = 8;
  localparam int BA_W = 3;
  localparam int A_W = 16;
  localparam int NBANK = 8;
  localparam int TMR_W = 4;

  // ----------------------------------------
  // latencies and timing, in link clock cycles
  // ----------------------------------------
  localparam int AL = 4;
  localparam int CL = 5;
  localparam int RL = AL + CL;
  localparam logic [TMR_W-1:0] T_RP = 4'h5;
  localparam logic [TMR_W-1:0] T_RTP = 4'h4;
  localparam logic [TMR_W-1:0] T_AP = T_RP + T_RTP;
  localparam logic [TMR_W-1:0] T_MRD = 4'h4;
  localparam logic [TMR_W-1:0] T_MOD = 4'hC;
  localparam logic [TMR_W-1:0] T_MRW = (T_MOD > T_MRD) ? T_MOD : T_MRD;
  localparam logic [TMR_W-1:0] T_CCD = 4'h4;
  localparam logic [2:0] BL8_LAST = 3'h7;
  localparam logic [2:0] BC4_LAST = 3'h3;
  // link clock half period in reference cycles, minus one
  localparam logic [1:0] CK_DIV_MAX = 2'h3;

  // ----------------------------------------
  // pin command codes {ras_n, cas_n, we_n}
  // ----------------------------------------
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_RD = 3'h5;
  localparam logic [2:0] CMD_NOP = 3'h7;

  // ----------------------------------------
  // address bit positions and mode values
  // ----------------------------------------
  localparam int A_AP = 10;
  localparam int A_BC = 12;
  localparam int A_MPR = 2;
  localparam int A_COLHI = 11;
  localparam logic [BA_W-1:0] MR3 = 3'h3;
  localparam logic [1:0] MPR_LOC = 2'h0;
  localparam logic [7:0] MPR_PATTERN = 8'hAA;

  // ----------------------------------------
  // controller registers
  // ----------------------------------------
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [3:0] REG_RD0 = 4'h8;
  localparam logic [3:0] REG_RD1 = 4'hC;
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_BA_LSB = 3;
  localparam int CMD_A_LSB = 6;
  localparam int ST_BUSY = 0;
  localparam int ST_MPR = 1;
  localparam int ST_REF = 2;
  localparam int ST_RV = 3;

  typedef enum logic [2:0] {OP_NOP, OP_ACT, OP_RD, OP_PRE, OP_MRS, OP_WR} smrrb_op_t;
endpackage

// File: common/smrrb_link_if.sv
`timescale 1ns/100ps
interface smrrb_link_if;
  // command side, driven by the controller
  logic ck;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [smrrb_pkg::BA_W-1:0] ba;
  logic [smrrb_pkg::A_W-1:0] addr;
  // data side, driven by the memory
  logic [smrrb_pkg::DQ_W-1:0] dq_drv;
  logic dq_oe;
  logic dqs_drv;
  logic dqs_oe;
  // resolved wire levels, undriven reads low
  logic [smrrb_pkg::DQ_W-1:0] dq;
  logic dqs;
  assign dq = dq_oe ? dq_drv : '0;
  assign dqs = dqs_oe ? dqs_drv : 1'h0;

  modport ctrl (output ck, cs_n, ras_n, cas_n, we_n, ba, addr, input dq, dqs);
  modport dram (input ck, cs_n, ras_n, cas_n, we_n, ba, addr, output dq_drv, dq_oe, dqs_drv, dqs_oe);
endinterface

// File: src/smrrb_sync.sv
`timescale 1ns/100ps
module smrrb_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // asynchronous input and synchronised output
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } smrrb_sync_t;

  smrrb_sync_t s;
  smrrb_sync_t next_s;

  // two stages, only the second is read
  always_comb begin
    next_s = s;
    next_s.s1 = d_i;
    next_s.s2 = s.s1;
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q_o = s.s2;
endmodule

// File: src/smrrb_ctrl.sv
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
module smrrb_ctrl (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // link to the memory
  smrrb_link_if.ctrl link,
  // register port
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o
);
  typedef struct packed {
    logic [1:0] div;
    logic ck;
    logic pend;
    smrrb_pkg::smrrb_op_t op;
    logic [smrrb_pkg::BA_W-1:0] pba;
    logic [smrrb_pkg::A_W-1:0] pa;
    logic cs_n;
    logic [2:0] rcw;
    logic [smrrb_pkg::BA_W-1:0] ba;
    logic [smrrb_pkg::A_W-1:0] addr;
    logic [smrrb_pkg::NBANK-1:0] open;
    logic [smrrb_pkg::NBANK-1:0][smrrb_pkg::TMR_W-1:0] tmr;
    logic [smrrb_pkg::TMR_W-1:0] t_mod;
    logic [smrrb_pkg::TMR_W-1:0] t_ccd;
    logic mpr;
    logic refused;
    logic dqs_q;
    logic [2:0] cnt;
    logic exp_bc4;
    logic [63:0] cap;
    logic [63:0] rdat;
    logic rvalid;
    logic [31:0] rdata;
  } smrrb_ctrl_t;

  smrrb_ctrl_t s;
  smrrb_ctrl_t next_s;
  logic [smrrb_pkg::DQ_W:0] in_s;
  logic set_ref;
  logic set_rv;
  logic clr;
  logic bad;
  logic ok;
  logic mpr_req;
  logic [smrrb_pkg::A_W-1:0] sa;
  logic [31:0] stat;

  // read data and strobe come from the memory's side
  smrrb_sync #(.W(smrrb_pkg::DQ_W + 1)) u_sync (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .d_i({link.dqs, link.dq}),
    .q_o(in_s)
  );

  // clock divider, command issue, capture and registers
  always_comb begin
    next_s = s;
    set_ref = 1'h0;
    set_rv = 1'h0;
    bad = 1'h0;
    ok = 1'h0;
    sa = s.pa;
    mpr_req = (s.pba == smrrb_pkg::MR3) && s.pa[smrrb_pkg::A_MPR];
    clr = rd_i && (addr_i == smrrb_pkg::REG_STAT);
    next_s.dqs_q = in_s[smrrb_pkg::DQ_W];
    next_s.div = s.div + 2'h1;
    if (s.div == smrrb_pkg::CK_DIV_MAX) begin
      next_s.div = '0;
      next_s.ck = ~s.ck;
      if (!s.ck) begin
        // rising link edge: count down waits
        for (int b = 0; b < smrrb_pkg::NBANK; b++) begin
          if (s.tmr[b] != '0) next_s.tmr[b] = s.tmr[b] - 4'h1;
        end
        if (s.t_mod != '0) next_s.t_mod = s.t_mod - 4'h1;
        if (s.t_ccd != '0) next_s.t_ccd = s.t_ccd - 4'h1;
      end else begin
        // falling link edge: pins change here
        next_s.cs_n = 1'h1;
        next_s.rcw = smrrb_pkg::CMD_NOP;
        if (s.pend) begin
          unique case (s.op)
            smrrb_pkg::OP_ACT: begin
              bad = s.mpr || s.open[s.pba];
              ok = (s.tmr[s.pba] == '0) && (s.t_mod == '0);
            end
            smrrb_pkg::OP_RD: begin
              bad = !(s.mpr || s.open[s.pba]);
              ok = (s.t_ccd == '0) && (s.t_mod == '0);
            end
            smrrb_pkg::OP_WR: begin
              bad = s.mpr || !s.open[s.pba];
              ok = (s.t_ccd == '0) && (s.t_mod == '0);
            end
            smrrb_pkg::OP_PRE: begin
              bad = s.mpr;
              ok = (s.t_mod == '0);
            end
            smrrb_pkg::OP_MRS: begin
              bad = mpr_req && (s.open != '0);
              ok = (s.t_mod == '0) && (s.t_ccd == '0) && (!mpr_req || (s.tmr == '0));
            end
            smrrb_pkg::OP_NOP: begin
              ok = 1'h1;
            end
            default: begin
              bad = 1'h1;
            end
          endcase
          if (bad) begin
            next_s.pend = 1'h0;
            set_ref = 1'h1;
          end else if (ok) begin
            next_s.pend = 1'h0;
            next_s.cs_n = (s.op == smrrb_pkg::OP_NOP);
            unique case (s.op)
              smrrb_pkg::OP_ACT: begin
                next_s.rcw = smrrb_pkg::CMD_ACT;
                next_s.open[s.pba] = 1'h1;
              end
              smrrb_pkg::OP_RD, smrrb_pkg::OP_WR: begin
                next_s.rcw = (s.op == smrrb_pkg::OP_RD) ? smrrb_pkg::CMD_RD : smrrb_pkg::CMD_WR;
                if (s.mpr) begin
                  // nibble start zero, chop bit as asked
                  sa[1:0] = 2'h0;
                  if (sa[smrrb_pkg::A_BC]) sa[smrrb_pkg::A_MPR] = 1'h0;
                end else if (sa[smrrb_pkg::A_AP]) begin
                  next_s.open[s.pba] = 1'h0;
                  next_s.tmr[s.pba] = smrrb_pkg::T_AP;
                end
                next_s.t_ccd = smrrb_pkg::T_CCD;
                if (s.op == smrrb_pkg::OP_RD) next_s.exp_bc4 = !sa[smrrb_pkg::A_BC];
              end
              smrrb_pkg::OP_PRE: begin
                next_s.rcw = smrrb_pkg::CMD_PRE;
                for (int b = 0; b < smrrb_pkg::NBANK; b++) begin
                  if (sa[smrrb_pkg::A_AP] || (s.pba == b[smrrb_pkg::BA_W-1:0])) begin
                    next_s.open[b] = 1'h0;
                    next_s.tmr[b] = smrrb_pkg::T_RP;
                  end
                end
              end
              smrrb_pkg::OP_MRS: begin
                next_s.rcw = smrrb_pkg::CMD_MRS;
                next_s.t_mod = smrrb_pkg::T_MRW;
                if (s.pba == smrrb_pkg::MR3) next_s.mpr = mpr_req && (s.pa[1:0] == smrrb_pkg::MPR_LOC);
              end
              default: begin
                next_s.rcw = smrrb_pkg::CMD_NOP;
              end
            endcase
            next_s.ba = s.pba;
            next_s.addr = sa;
          end
        end
      end
    end
    // capture one byte per strobe edge
    if (in_s[smrrb_pkg::DQ_W] != s.dqs_q) begin
      next_s.cap[{s.cnt, 3'h0} +: 8] = in_s[smrrb_pkg::DQ_W-1:0];
      next_s.cnt = s.cnt + 3'h1;
      if (s.cnt == (s.exp_bc4 ? smrrb_pkg::BC4_LAST : smrrb_pkg::BL8_LAST)) begin
        next_s.cnt = '0;
        next_s.rdat = next_s.cap;
        set_rv = 1'h1;
      end
    end
    // command register write
    if (wr_i && (addr_i == smrrb_pkg::REG_CMD)) begin
      if (s.pend) begin
        set_ref = 1'h1;
      end else begin
        next_s.pend = 1'h1;
        next_s.op = smrrb_pkg::smrrb_op_t'(wdata_i[smrrb_pkg::CMD_OP_LSB +: 3]);
        next_s.pba = wdata_i[smrrb_pkg::CMD_BA_LSB +: smrrb_pkg::BA_W];
        next_s.pa = wdata_i[smrrb_pkg::CMD_A_LSB +: smrrb_pkg::A_W];
      end
    end
    // sticky flags, set wins over clear
    next_s.refused = set_ref || (s.refused && !clr);
    next_s.rvalid = set_rv || (s.rvalid && !clr);
    stat = '0;
    stat[smrrb_pkg::ST_BUSY] = s.pend;
    stat[smrrb_pkg::ST_MPR] = s.mpr;
    stat[smrrb_pkg::ST_REF] = s.refused;
    stat[smrrb_pkg::ST_RV] = s.rvalid;
    next_s.rdata = '0;
    if (rd_i) begin
      unique case (addr_i)
        smrrb_pkg::REG_STAT: next_s.rdata = stat;
        smrrb_pkg::REG_RD0: next_s.rdata = s.rdat[31:0];
        smrrb_pkg::REG_RD1: next_s.rdata = s.rdat[63:32];
        default: next_s.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s <= '0;
      s.cs_n <= 1'h1;
      s.rcw <= smrrb_pkg::CMD_NOP;
    end else begin
      s <= next_s;
    end
  end

  // outputs
  assign link.ck = s.ck;
  assign link.cs_n = s.cs_n;
  assign link.ras_n = s.rcw[2];
  assign link.cas_n = s.rcw[1];
  assign link.we_n = s.rcw[0];
  assign link.ba = s.ba;
  assign link.addr = s.addr;
  assign rdata_o = s.rdata;
endmodule

// File: src/smrrb_dram.sv
`timescale 1ns/100ps
module smrrb_dram (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // link from the controller
  smrrb_link_if.dram link,
  // status
  output logic mpr_en_o,
  output logic [smrrb_pkg::NBANK-1:0] bank_open_o
);
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_PRE, ST_DATA, ST_POST} smrrb_bst_t;

  // one read waiting in the latency pipe
  typedef struct packed {
    logic vld;
    logic bc4;
    logic mpr;
    logic [2:0] idx0;
    logic [7:0] base;
  } smrrb_rd_t;

  typedef struct packed {
    logic ck_q;
    smrrb_rd_t [smrrb_pkg::RL-1:0] pipe;
    logic [smrrb_pkg::NBANK-1:0] open;
    logic [smrrb_pkg::NBANK-1:0][smrrb_pkg::A_W-1:0] row;
    logic [smrrb_pkg::NBANK-1:0][smrrb_pkg::TMR_W-1:0] tmr;
    logic mpr;
    smrrb_bst_t st;
    logic bc4;
    logic bmpr;
    logic [2:0] beat;
    logic [2:0] idx0;
    logic [7:0] base;
    logic [smrrb_pkg::DQ_W-1:0] dq;
    logic dq_oe;
    logic dqs_tgt;
    logic dqs;
    logic dqs_oe;
  } smrrb_dram_t;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  smrrb_dram_t s;
  smrrb_dram_t next_s;
  logic [1 + 4 + smrrb_pkg::BA_W + smrrb_pkg::A_W - 1:0] pin_s;
  logic ck_s;
  logic cs_n;
  logic [2:0] rcw;
  logic [smrrb_pkg::BA_W-1:0] ba;
  logic [smrrb_pkg::A_W-1:0] a;
  logic [10:0] col;
  logic rise;
  logic fall;
  logic last;
  logic go;
  logic [2:0] nb;
  smrrb_rd_t ent;
  smrrb_rd_t head;
  smrrb_rd_t nxt;

  // data for one beat of a burst
  function automatic logic [smrrb_pkg::DQ_W-1:0] beat_data(input logic m, input logic [7:0] base,
                                                          input logic [2:0] idx);
    if (m) begin
      beat_data = {smrrb_pkg::DQ_W{smrrb_pkg::MPR_PATTERN[idx]}};
    end else begin
      beat_data = base ^ {5'h00, idx};
    end
  endfunction

  // ----------------------------------------
  // pin synchroniser
  // ----------------------------------------
  // link clock and command pins all come from the other party
  smrrb_sync #(.W(1 + 4 + smrrb_pkg::BA_W + smrrb_pkg::A_W)) u_sync (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .d_i({link.ck, link.cs_n, link.ras_n, link.cas_n, link.we_n, link.ba, link.addr}),
    .q_o(pin_s)
  );

  // split synchronised pins
  assign a = pin_s[smrrb_pkg::A_W-1:0];
  assign ba = pin_s[smrrb_pkg::A_W +: smrrb_pkg::BA_W];
  assign rcw = pin_s[smrrb_pkg::A_W + smrrb_pkg::BA_W +: 3];
  assign cs_n = pin_s[smrrb_pkg::A_W + smrrb_pkg::BA_W + 3];
  assign ck_s = pin_s[smrrb_pkg::A_W + smrrb_pkg::BA_W + 4];

  // ----------------------------------------
  // command decode, banks and read bursts
  // ----------------------------------------
  always_comb begin
    next_s = s;
    ent = '0;
    go = 1'h0;
    nb = s.beat + 3'h1;
    rise = ck_s && !s.ck_q;
    fall = !ck_s && s.ck_q;
    head = s.pipe[smrrb_pkg::RL-1];
    nxt = s.pipe[smrrb_pkg::RL-2];
    last = (s.beat == (s.bc4 ? smrrb_pkg::BC4_LAST : smrrb_pkg::BL8_LAST));
    // chop bit left out of the column
    col = {a[smrrb_pkg::A_COLHI], a[9:0]};
    next_s.ck_q = ck_s;
    // strobe follows data by one reference cycle
    next_s.dqs = s.dqs_tgt;

    if (rise) begin
      // precharge timers run on link clock rises
      for (int b = 0; b < smrrb_pkg::NBANK; b++) begin
        if (s.tmr[b] != '0) next_s.tmr[b] = s.tmr[b] - 4'h1;
      end
      if (!cs_n) begin
        unique case (rcw)
          smrrb_pkg::CMD_ACT: begin
            // open row once precharge time is over
            // timer already stepped for this rise, so an activate spaced exactly by the period is taken
            if (!s.open[ba] && (next_s.tmr[ba] == '0)) begin
              next_s.open[ba] = 1'h1;
              next_s.row[ba] = a;
            end
          end
          smrrb_pkg::CMD_PRE: begin
            // close one or all, period restarts
            for (int b = 0; b < smrrb_pkg::NBANK; b++) begin
              if (a[smrrb_pkg::A_AP] || (ba == b[smrrb_pkg::BA_W-1:0])) begin
                next_s.open[b] = 1'h0;
                next_s.tmr[b] = smrrb_pkg::T_RP;
              end
            end
          end
          smrrb_pkg::CMD_MRS: begin
            if (ba == smrrb_pkg::MR3) begin
              next_s.mpr = a[smrrb_pkg::A_MPR] && (a[1:0] == smrrb_pkg::MPR_LOC);
            end
          end
          smrrb_pkg::CMD_RD: begin
            if (s.mpr || s.open[ba]) begin
              ent.vld = 1'h1;
              ent.mpr = s.mpr;
              // chop bit low gives four beats
              ent.bc4 = !a[smrrb_pkg::A_BC];
              // nibble picked by A2 when chopped
              ent.idx0 = ent.bc4 ? {a[smrrb_pkg::A_MPR], 2'h0} : 3'h0;
              ent.base = s.row[ba][7:0] ^ {col[7:3], 3'h0};
            end
            // auto precharge in normal mode
            if (!s.mpr && s.open[ba] && a[smrrb_pkg::A_AP]) begin
              next_s.open[ba] = 1'h0;
              next_s.tmr[ba] = smrrb_pkg::T_AP;
            end
          end
          default: begin
            // writes carry no data path here
            next_s.open = s.open;
          end
        endcase
      end
      // read latency pipe, one stage per clock
      next_s.pipe = {s.pipe[smrrb_pkg::RL-2:0], ent};
      go = head.vld && ((s.st == ST_PRE) || ((s.st == ST_DATA) && last));
      if (go) begin
        // first beat of a burst
        next_s.st = ST_DATA;
        next_s.beat = '0;
        next_s.bc4 = head.bc4;
        next_s.bmpr = head.mpr;
        next_s.idx0 = head.idx0;
        next_s.base = head.base;
        next_s.dq = beat_data(head.mpr, head.base, head.idx0);
        next_s.dq_oe = 1'h1;
        next_s.dqs_oe = 1'h1;
        next_s.dqs_tgt = 1'h1;
      end else begin
        unique case (s.st)
          ST_IDLE: begin
            if (nxt.vld) begin
              next_s.st = ST_PRE;
              next_s.dqs_oe = 1'h1;
              next_s.dqs_tgt = 1'h0;
            end
          end
          ST_PRE: begin
            next_s.st = ST_IDLE;
            next_s.dqs_oe = 1'h0;
          end
          ST_DATA: begin
            if (last) begin
              next_s.dq_oe = 1'h0;
              next_s.st = nxt.vld ? ST_PRE : ST_POST;
            end else begin
              next_s.beat = nb;
              next_s.dq = beat_data(s.bmpr, s.base, s.idx0 + nb);
              next_s.dqs_tgt = !nb[0];
            end
          end
          ST_POST: begin
            next_s.st = ST_POST;
          end
        endcase
      end
    end else if (fall) begin
      unique case (s.st)
        ST_DATA: begin
          next_s.beat = nb;
          next_s.dq = beat_data(s.bmpr, s.base, s.idx0 + nb);
          next_s.dqs_tgt = !nb[0];
        end
        ST_POST: begin
          // postamble ends half a clock later
          next_s.st = ST_IDLE;
          next_s.dqs_oe = 1'h0;
        end
        ST_IDLE, ST_PRE: begin
          next_s.st = s.st;
        end
      endcase
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // outputs
  assign link.dq_drv = s.dq;
  assign link.dq_oe = s.dq_oe;
  assign link.dqs_drv = s.dqs;
  assign link.dqs_oe = s.dqs_oe;
  assign mpr_en_o = s.mpr;
  assign bank_open_o = s.open;
endmodule

// File: tb/smrrb_monitor.sv
`timescale 1ns/100ps
module smrrb_monitor (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // link signals
  input wire logic ck,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [smrrb_pkg::BA_W-1:0] ba,
  input wire logic [smrrb_pkg::A_W-1:0] addr,
  input wire logic [smrrb_pkg::DQ_W-1:0] dq_drv,
  input wire logic dq_oe,
  input wire logic dqs_drv,
  input wire logic dqs_oe
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  logic [7:0] beat_cnt;
  // ref cycles with data driven
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      beat_cnt <= 8'h00;
    end else begin
      beat_cnt <= dq_oe ? beat_cnt + 8'h01 : 8'h00;
    end
  end
  property p_ck_half; $rose(ck) |-> ##4 $fell(ck); endproperty
  a_ck_half: assert property (p_ck_half) else $error("link clock half period wrong");
  property p_cmd_edge; $changed({cs_n, ras_n, cas_n, we_n}) |-> $fell(ck); endproperty
  a_cmd_edge: assert property (p_cmd_edge) else $error("command pins moved off clock fall");
  property p_cmd_hold; (!cs_n && $fell(ck)) |=> $stable({cs_n, ras_n, cas_n, we_n, ba, addr})[*7]; endproperty
  a_cmd_hold: assert property (p_cmd_hold) else $error("command not held one clock");
  property p_dq_in_dqs; dq_oe |-> dqs_oe; endproperty
  a_dq_in_dqs: assert property (p_dq_in_dqs) else $error("data driven without strobe");
  property p_preamble; $rose(dqs_oe) |-> (!dq_oe && !dqs_drv)[*6] ##[1:3] dq_oe; endproperty
  a_preamble: assert property (p_preamble) else $error("preamble wrong");
  property p_beats; $fell(dq_oe) |-> (beat_cnt[3:0] == 4'h0) && (beat_cnt != 8'h00); endproperty
  a_beats: assert property (p_beats) else $error("burst length wrong");
  property p_dqs_follow; (dq_oe && $changed(dq_drv)) |=> $changed(dqs_drv); endproperty
  a_dqs_follow: assert property (p_dqs_follow) else $error("strobe did not follow data");
  property p_postamble; $fell(dq_oe) |-> (dqs_oe && !dqs_drv)[*3] ##[1:3] !dqs_oe; endproperty
  a_postamble: assert property (p_postamble) else $error("postamble wrong");
  // read on the pins: preamble, then beat 0 nine link clocks after the taking rise, plus sync delay
  property p_rd_lat;
    (!cs_n && $fell(ck) && ras_n && !cas_n && we_n) |-> ##78 (dqs_oe && !dqs_drv) ##1 dq_oe;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read data not at read latency");
endmodule

// File: tb/tb_sdram_mpr_row_read_burst.sv
`timescale 1ns/100ps
module tb_sdram_mpr_row_read_burst;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic mpr_en_o;
  logic [7:0] bank_open_o;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h7DA18A62;
  logic ref_flag;
  logic done_flag;
  smrrb_link_if link ();
  smrrb_ctrl u_smrrb_ctrl (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .link(link), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));
  smrrb_dram u_smrrb_dram (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .link(link), .mpr_en_o(mpr_en_o),
    .bank_open_o(bank_open_o));
  smrrb_monitor u_smrrb_monitor (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .ck(link.ck), .cs_n(link.cs_n),
    .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n), .ba(link.ba), .addr(link.addr),
    .dq_drv(link.dq_drv), .dq_oe(link.dq_oe), .dqs_drv(link.dqs_drv), .dqs_oe(link.dqs_oe));
  // ----------------------------------------
  // clock, timeout and helpers
  // ----------------------------------------
  always #5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      miscompares = miscompares + 1;
      results();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // four expected bytes from a first beat
  function automatic logic [31:0] exp_rd(logic [7:0] row, logic [15:0] a, int first, logic pat);
    logic [31:0] w;
    for (int i = 0; i < 4; i++) begin
      w[8*i+:8] = pat ? {8{smrrb_pkg::MPR_PATTERN[first+i]}} : row ^ {a[7:3], 3'h0} ^ 8'(first + i);
    end
    return w;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  // issue one command and wait for it to finish
  task automatic cmd(input smrrb_pkg::smrrb_op_t op, input logic [2:0] b, input logic [15:0] a);
    logic [31:0] s;
    reg_wr(smrrb_pkg::REG_CMD, {10'h000, a, b, op});
    ref_flag = 1'b0;
    done_flag = 1'b0;
    repeat (400) begin
      reg_rd(smrrb_pkg::REG_STAT, s);
      ref_flag |= s[2];
      done_flag |= s[3];
      if (!s[0] && (op != smrrb_pkg::OP_RD || done_flag || ref_flag)) break;
    end
    repeat (16) @(posedge ref_clk_i);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] d;
    logic [2:0] b;
    logic [15:0] r;
    logic [15:0] c;
    repeat (6) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      b = 3'(rnd());
      r = 16'(rnd());
      c = (16'(rnd()) & 16'h01F8) | 16'h1000;
      cmd(smrrb_pkg::OP_ACT, b, r);
      chk(32'(bank_open_o[b]), 32'h1);
      cmd(smrrb_pkg::OP_RD, b, c);
      reg_rd(smrrb_pkg::REG_RD0, d);
      chk(d, exp_rd(r[7:0], c, 0, 1'b0));
      reg_rd(smrrb_pkg::REG_RD1, d);
      chk(d, exp_rd(r[7:0], c, 4, 1'b0));
      cmd(smrrb_pkg::OP_RD, b, (c & 16'hEFFF) | 16'h0004);
      reg_rd(smrrb_pkg::REG_RD0, d);
      chk(d, exp_rd(r[7:0], c, 4, 1'b0));
      cmd(smrrb_pkg::OP_ACT, b, r ^ 16'h0001);
      chk(32'(ref_flag), 32'h1);
      cmd(smrrb_pkg::OP_PRE, b, 16'h0000);
      chk(32'(bank_open_o[b]), 32'h0);
      cmd(smrrb_pkg::OP_RD, b, c);
      chk(32'(ref_flag), 32'h1);
      cmd(smrrb_pkg::OP_PRE, b, 16'h0000);
      chk(32'(ref_flag), 32'h0);
      // reopen at the earliest legal edge, then read with auto precharge
      cmd(smrrb_pkg::OP_ACT, b, r);
      chk(32'(bank_open_o[b]), 32'h1);
      cmd(smrrb_pkg::OP_RD, b, c | 16'h0400);
      reg_rd(smrrb_pkg::REG_RD1, d);
      chk(d, exp_rd(r[7:0], c, 4, 1'b0));
      chk(32'(bank_open_o[b]), 32'h0);
    end
    $display("test array reads done");
    cmd(smrrb_pkg::OP_ACT, 3'h2, r);
    cmd(smrrb_pkg::OP_MRS, smrrb_pkg::MR3, 16'h0004);
    chk(32'(ref_flag), 32'h1);
    cmd(smrrb_pkg::OP_PRE, 3'h0, 16'h0400);
    chk(32'(bank_open_o), 32'h0);
    cmd(smrrb_pkg::OP_MRS, smrrb_pkg::MR3, 16'h0004);
    chk(32'(mpr_en_o), 32'h1);
    cmd(smrrb_pkg::OP_RD, 3'h5, 16'h15F8);
    reg_rd(smrrb_pkg::REG_RD0, d);
    chk(d, exp_rd(8'h00, 16'h0000, 0, 1'b1));
    reg_rd(smrrb_pkg::REG_RD1, d);
    chk(d, exp_rd(8'h00, 16'h0000, 4, 1'b1));
    for (int n = 1; n >= 0; n--) begin
      cmd(smrrb_pkg::OP_RD, 3'h0, n ? 16'h0004 : 16'h0000);
      reg_rd(smrrb_pkg::REG_RD0, d);
      chk(d, exp_rd(8'h00, 16'h0000, 4 * n, 1'b1));
    end
    cmd(smrrb_pkg::OP_WR, 3'h0, 16'h0000);
    chk(32'(ref_flag), 32'h1);
    cmd(smrrb_pkg::OP_MRS, smrrb_pkg::MR3, 16'h0000);
    chk(32'(mpr_en_o), 32'h0);
    $display("test pattern reads done");
    results();
  end
endmodule
